// ==== rtl/hio_consts.svh ====
// How it works
// - registers sit directly on the host bus from offset 50h to B4h
// - identity word: chip code high half, revision low half, writes ignored
// - byte order probe at 64h always reads 87654321h
// - hold-off interval field 31:24 counts 10 us units, read/write, resets zero
// - writing zero interval stops hold-off, clears counter, releases pending interrupts
// - a new non-zero interval governs every later hold-off
// - power event interrupt bypasses the hold-off gating
// - writing one to bit 14 restarts the hold-off interval, bit self-clears
// - bit 13 reads one while hold-off withholds interrupts from the pin
// - bit 12 shows combined enabled request, regardless of enable or hold-off
// - enable bit 8 clear keeps the pin deasserted, status untouched
// - polarity bit 4: zero active low, one active high, push-pull only
// - type bit 0: zero open-drain active low, one push-pull
// - polarity and type survive software reset, cleared only by hardware reset
// - host clears status bits by writing ones, zeros leave bits alone
`ifndef HIO_CONSTS_SVH
`define HIO_CONSTS_SVH
`define HIO_OFF_ID 8'h50
`define HIO_OFF_CFG 8'h54
`define HIO_OFF_STS 8'h58
`define HIO_OFF_EN 8'h5C
`define HIO_OFF_PROBE 8'h64
`define HIO_OFF_LAST 8'hB4
`define HIO_PROBE_VAL 32'h87654321
`define HIO_CHIP_ID 16'hA5C3
`define HIO_CHIP_REV 16'h0000
`define HIO_RST_ZERO 32'h00000000
`define HIO_F_INT_HI 31
`define HIO_F_INT_LO 24
`define HIO_F_RESTART 14
`define HIO_F_ACTIVE 13
`define HIO_F_IRQ 12
`define HIO_F_EN 8
`define HIO_F_POL 4
`define HIO_F_TYPE 0
`define HIO_PWR_EVT_BIT 17
`define HIO_UNIT_NS 10000
`define HIO_CLK_NS 50
`define HIO_UNIT_CYC (`HIO_UNIT_NS / `HIO_CLK_NS)
`endif

// ==== rtl/hio_pkg.sv ====
package hio_pkg;
    typedef enum logic [1:0] {
        HIO_FREE,
        HIO_HOLD
    } hio_hold_t;
endpackage : hio_pkg

// ==== rtl/hio_tick_gen.sv ====
`timescale 1ns/1ns
`include "hio_consts.svh"
module hio_tick_gen #(
    parameter int UNIT_CYC = `HIO_UNIT_CYC
) (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic restart_in,
    output logic tick_out
);
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic tick_next;
    // ---------------------------------
    // 10 us time base
    // ---------------------------------
    assign tick_next = !restart_in && (cnt_reg == 16'(UNIT_CYC - 1));
    assign cnt_next = (restart_in || tick_next) ? 16'h0000 : cnt_reg + 16'h0001;
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_reg <= 16'h0000;
            tick_out <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_out <= tick_next;
        end
    end
endmodule : hio_tick_gen

// ==== rtl/hio_irq_top.sv ====
`timescale 1ns/1ns
`include "hio_consts.svh"
module hio_irq_top #(
    parameter logic [15:0] CHIP_ID = `HIO_CHIP_ID, // arbitrary value
    parameter logic [15:0] CHIP_REV = `HIO_CHIP_REV,
    parameter int UNIT_CYC = `HIO_UNIT_CYC
) (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic soft_reset_in,
    input wire logic [7:0] addr_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [31:0] wdata_in,
    input wire logic [31:0] int_src_in,
    output logic [31:0] rdata_out,
    output logic irq_out,
    output logic irq_oe_out
);
    // ---------------------------------
    // state
    // ---------------------------------
    logic [31:0] sts_reg;
    logic [31:0] en_reg;
    logic [7:0] interval_reg;
    logic [7:0] cnt_reg;
    logic cfg_en_reg;
    logic pol_reg;
    logic type_reg;
    logic other_dlv_reg;
    hio_pkg::hio_hold_t hold_reg;
    hio_pkg::hio_hold_t hold_next;
    logic [7:0] cnt_next;
    logic [31:0] sts_next;
    logic [31:0] rdata_next;
    logic irq_next;
    logic oe_next;
    logic tick;
    // ---------------------------------
    // decode
    // ---------------------------------
    wire cfg_wr = wr_en_in && (addr_in == `HIO_OFF_CFG);
    wire sts_wr = wr_en_in && (addr_in == `HIO_OFF_STS);
    wire en_wr = wr_en_in && (addr_in == `HIO_OFF_EN);
    wire [7:0] new_int = wdata_in[`HIO_F_INT_HI:`HIO_F_INT_LO];
    wire zero_wr = cfg_wr && (new_int == 8'h00);
    wire restart_wr = cfg_wr && wdata_in[`HIO_F_RESTART] && !zero_wr;
    wire [31:0] active_src = sts_reg & en_reg;
    wire irq_int = |active_src;
    wire pwr_evt_req = active_src[`HIO_PWR_EVT_BIT];
    wire other_req = |(active_src & ~(32'h00000001 << `HIO_PWR_EVT_BIT));
    wire holding = (hold_reg == hio_pkg::HIO_HOLD);
    wire other_dlv = other_req && !holding;
    wire deliver = other_dlv || pwr_evt_req;
    wire [7:0] load_val = cfg_wr ? new_int : interval_reg;
    wire fall_start = other_dlv_reg && !other_dlv && (interval_reg != 8'h00);
    wire start = !zero_wr && (restart_wr || fall_start);
    wire assert_pin = cfg_en_reg && deliver;
    wire [31:0] cfg_word = {interval_reg, 9'h000, 1'b0, holding, irq_int, 3'h0,
                            cfg_en_reg, 3'h0, pol_reg, 3'h0, type_reg};
    // ---------------------------------
    // time base
    // ---------------------------------
    hio_tick_gen #(
        .UNIT_CYC(UNIT_CYC)
    ) u_tick (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .restart_in(start),
        .tick_out(tick)
    );
    // ---------------------------------
    // hold-off sequencing
    // ---------------------------------
    always_comb begin
        hold_next = hold_reg;
        cnt_next = cnt_reg;
        case (hold_reg)
            hio_pkg::HIO_FREE: begin
                if (start) begin
                    hold_next = hio_pkg::HIO_HOLD;
                    cnt_next = load_val;
                end
            end
            hio_pkg::HIO_HOLD: begin
                if (start) begin
                    cnt_next = load_val;
                end else if (tick) begin
                    cnt_next = cnt_reg - 8'h01;
                    if (cnt_reg == 8'h01) begin
                        hold_next = hio_pkg::HIO_FREE;
                    end
                end
            end
            default: begin
                hold_next = hio_pkg::HIO_FREE;
                cnt_next = 8'h00;
            end
        endcase
        if (zero_wr || soft_reset_in) begin
            hold_next = hio_pkg::HIO_FREE;
            cnt_next = 8'h00;
        end
    end
    // ---------------------------------
    // status, read data, pin
    // ---------------------------------
    assign sts_next = soft_reset_in ? int_src_in :
        ((sts_reg & ~(sts_wr ? wdata_in : 32'h00000000)) | int_src_in);
    assign rdata_next = !rd_en_in ? 32'h00000000 :
        (addr_in == `HIO_OFF_ID) ? {CHIP_ID, CHIP_REV} :
        (addr_in == `HIO_OFF_CFG) ? cfg_word :
        (addr_in == `HIO_OFF_STS) ? sts_reg :
        (addr_in == `HIO_OFF_EN) ? en_reg :
        (addr_in == `HIO_OFF_PROBE) ? `HIO_PROBE_VAL : 32'h00000000;
    assign irq_next = type_reg ? (pol_reg ? assert_pin : !assert_pin) : 1'b0;
    assign oe_next = type_reg ? 1'b1 : assert_pin;
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sts_reg <= `HIO_RST_ZERO;
            en_reg <= `HIO_RST_ZERO;
            interval_reg <= 8'h00;
            cfg_en_reg <= 1'b0;
            other_dlv_reg <= 1'b0;
            hold_reg <= hio_pkg::HIO_FREE;
            cnt_reg <= 8'h00;
            rdata_out <= 32'h00000000;
            irq_out <= 1'b0;
            irq_oe_out <= 1'b0;
        end else begin
            sts_reg <= sts_next;
            en_reg <= soft_reset_in ? `HIO_RST_ZERO : (en_wr ? wdata_in : en_reg);
            if (soft_reset_in) begin
                interval_reg <= 8'h00;
                cfg_en_reg <= 1'b0;
            end else if (cfg_wr) begin
                interval_reg <= new_int;
                cfg_en_reg <= wdata_in[`HIO_F_EN];
            end
            other_dlv_reg <= other_dlv;
            hold_reg <= hold_next;
            cnt_reg <= cnt_next;
            rdata_out <= rdata_next;
            irq_out <= irq_next;
            irq_oe_out <= oe_next;
        end
    end
    // polarity and type: hardware reset only
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pol_reg <= 1'b0;
            type_reg <= 1'b0;
        end else if (cfg_wr) begin
            pol_reg <= wdata_in[`HIO_F_POL];
            type_reg <= wdata_in[`HIO_F_TYPE];
        end
    end
    // ---------------------------------
    // checks
    // ---------------------------------
    property p_probe;
        @(posedge mclk_in) disable iff (!resetn_in)
        rd_en_in && (addr_in == `HIO_OFF_PROBE) |=> rdata_out == 32'h87654321;
    endproperty
    a_probe: assert property (p_probe) else $error("probe word wrong");
    property p_ident;
        @(posedge mclk_in) disable iff (!resetn_in)
        rd_en_in && (addr_in == `HIO_OFF_ID) |=> rdata_out == {CHIP_ID, CHIP_REV};
    endproperty
    a_ident: assert property (p_ident) else $error("identity word wrong");
    property p_zero;
        @(posedge mclk_in) disable iff (!resetn_in)
        zero_wr |=> !holding && (cnt_reg == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero interval kept hold-off");
    property p_restart;
        @(posedge mclk_in) disable iff (!resetn_in)
        restart_wr && !soft_reset_in |=> holding && (cnt_reg == $past(new_int));
    endproperty
    a_restart: assert property (p_restart) else $error("restart not loaded");
    property p_master;
        @(posedge mclk_in) disable iff (!resetn_in)
        rd_en_in && (addr_in == `HIO_OFF_CFG) |=> rdata_out[12] == $past(irq_int);
    endproperty
    a_master: assert property (p_master) else $error("master bit wrong");
    property p_disabled;
        @(posedge mclk_in) disable iff (!resetn_in)
        !cfg_en_reg && type_reg |=> irq_out == !$past(pol_reg);
    endproperty
    a_disabled: assert property (p_disabled) else $error("pin asserted while off");
    property p_opendrain;
        @(posedge mclk_in) disable iff (!resetn_in)
        !type_reg |=> !irq_out && (irq_oe_out == $past(assert_pin));
    endproperty
    a_opendrain: assert property (p_opendrain) else $error("open-drain drive wrong");
    property p_power_event;
        @(posedge mclk_in) disable iff (!resetn_in)
        pwr_evt_req && cfg_en_reg && type_reg && pol_reg |=> irq_out;
    endproperty
    a_power_event: assert property (p_power_event) else $error("power event held off");
    property p_hold;
        @(posedge mclk_in) disable iff (!resetn_in)
        holding && !pwr_evt_req && type_reg && pol_reg |=> !irq_out;
    endproperty
    a_hold: assert property (p_hold) else $error("pin asserted in hold-off");
    property p_ack;
        @(posedge mclk_in) disable iff (!resetn_in)
        sts_wr && !soft_reset_in |=> (sts_reg & $past(wdata_in & ~int_src_in)) == 32'h0;
    endproperty
    a_ack: assert property (p_ack) else $error("acknowledge failed");
    property p_keep;
        @(posedge mclk_in) disable iff (!resetn_in)
        soft_reset_in && !cfg_wr |=> pol_reg == $past(pol_reg) && type_reg == $past(type_reg);
    endproperty
    a_keep: assert property (p_keep) else $error("pin config lost");
endmodule : hio_irq_top

// ==== testbench/hio_host_pin.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// host side of the interrupt line
// ----------------------------------------
module hio_host_pin (
    input wire logic irq_in,
    input wire logic irq_oe_in,
    output logic pin_level_out
);
    // released line pulled up, as a wired-or line
    assign pin_level_out = irq_oe_in ? irq_in : 1'b1;
endmodule : hio_host_pin

// ==== testbench/host_irq_output_and_id_test.sv ====
`timescale 1ns/1ns
module host_irq_output_and_id_test;
    logic mclk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic soft_reset_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic wr_en_in = 1'b0;
    logic rd_en_in = 1'b0;
    logic [31:0] wdata_in = 32'h00000000;
    logic [31:0] int_src_in = 32'h00000000;
    logic [31:0] rdata_out;
    logic irq_out;
    logic irq_oe_out;
    logic pin;
    int n_errors = 0;
    int n_compared = 0;
    always #25 mclk_in = ~mclk_in;
    // id value arbitrary
    hio_irq_top #(.CHIP_ID(16'h1234), .CHIP_REV(16'h0007), .UNIT_CYC(4)) dut (
        .mclk_in(mclk_in), .resetn_in(resetn_in), .soft_reset_in(soft_reset_in),
        .addr_in(addr_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
        .wdata_in(wdata_in), .int_src_in(int_src_in), .rdata_out(rdata_out),
        .irq_out(irq_out), .irq_oe_out(irq_oe_out));
    hio_host_pin host (.irq_in(irq_out), .irq_oe_in(irq_oe_out), .pin_level_out(pin));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(negedge mclk_in);
    endtask : wt
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge mclk_in);
        addr_in = a;
        wdata_in = d;
        wr_en_in = 1'b1;
        @(negedge mclk_in);
        wr_en_in = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(negedge mclk_in);
        addr_in = a;
        rd_en_in = 1'b1;
        @(negedge mclk_in);
        rd_en_in = 1'b0;
        chk(rdata_out, exp);
    endtask : rd
    task automatic pulse(input logic [31:0] bits);
        @(negedge mclk_in);
        int_src_in = bits;
        @(negedge mclk_in);
        int_src_in = 32'h00000000;
    endtask : pulse
    task automatic pinchk(input logic e);
        wt(3);
        chk({31'h0, pin}, {31'h0, e});
    endtask : pinchk
    task automatic final_report;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        #200000;
        n_errors++;
        final_report();
    end
    initial begin
        wt(16);
        resetn_in = 1'b1;
        rd(8'h50, 32'h12340007);
        rd(8'h64, 32'h87654321);
        rd(8'h54, 32'h00000000);
        rd(8'h58, 32'h00000000);
        wr(8'h50, 32'hFFFFFFFF);
        wr(8'h64, 32'h00000000);
        rd(8'h50, 32'h12340007);
        rd(8'h64, 32'h87654321);
        rd(8'h60, 32'h00000000);
        wr(8'h5C, 32'h00020003);
        rd(8'h5C, 32'h00020003);
        pinchk(1'b1);
        $display("test 1 done");
        pulse(32'h00000003);
        rd(8'h58, 32'h00000003);
        rd(8'h54, 32'h00001000);
        pinchk(1'b1);
        wr(8'h54, 32'h00000100);
        pinchk(1'b0);
        wr(8'h54, 32'h00000110);
        pinchk(1'b0);
        wr(8'h54, 32'h00000111);
        pinchk(1'b1);
        wr(8'h54, 32'h00000101);
        pinchk(1'b0);
        wr(8'h58, 32'h00000001);
        rd(8'h58, 32'h00000002);
        wr(8'h58, 32'h00000002);
        rd(8'h58, 32'h00000000);
        pinchk(1'b1);
        $display("test 2 done");
        wr(8'h54, 32'h0A000111);
        pulse(32'h00000001);
        pinchk(1'b1);
        wr(8'h58, 32'h00000001);
        wt(2);
        rd(8'h54, 32'h0A002111);
        pulse(32'h00000001);
        pinchk(1'b0);
        pulse(32'h00020000);
        pinchk(1'b1);
        wr(8'h58, 32'h00020000);
        pinchk(1'b0);
        wr(8'h54, 32'h00000111);
        pinchk(1'b1);
        rd(8'h54, 32'h00001111);
        wr(8'h54, 32'h02000111);
        wr(8'h58, 32'h00000001);
        wt(3);
        rd(8'h54, 32'h02002111);
        wt(20);
        rd(8'h54, 32'h02000111);
        wr(8'h54, 32'h02004111);
        rd(8'h54, 32'h02002111);
        $display("test 3 done");
        @(negedge mclk_in);
        soft_reset_in = 1'b1;
        @(negedge mclk_in);
        soft_reset_in = 1'b0;
        rd(8'h54, 32'h00000011);
        rd(8'h5C, 32'h00000000);
        $display("test 4 done");
        final_report();
    end
endmodule : host_irq_output_and_id_test
